// ### gpio_consts.vh
// Purpose: constants of the pin status and output mux block
// Assumes: register indices are word indices on the bus
// Notes: byte address of a register is four times its index
`ifndef GPIO_CONSTS_VH
`define GPIO_CONSTS_VH

// Register indices
`define IDX_PIN_STATUS 6'h0E
`define IDX_INPUT_EN 6'h0F
`define IDX_PIN0_CTL 6'h10
`define IDX_PIN1_CTL 6'h11
`define IDX_PIN7_CTL 6'h17

// Reset values
`define RST_INPUT_EN 8'hFF
`define RST_PIN_CTL 8'h00
`define RST_PIN_STATUS 8'h00

// Control register fields
`define CTL_DRV_EN_BIT 0
`define CTL_SW_LEVEL_BIT 1
`define CTL_SRC_HI 4
`define CTL_SRC_LO 2
`define CTL_SEL_HI 7
`define CTL_SEL_LO 5

// Source codes
`define SRC_DEV_STATUS 3'h4
`define SRC_OUT_PORT0 3'h6

// Receive port selections (100 upward)
`define RXSEL_LOCK 3'h4
`define RXSEL_PASS 3'h5
`define RXSEL_FV 3'h6
`define RXSEL_LV 3'h7

// Device status selections
`define DEVSEL_SW_LEVEL 3'h0
`define DEVSEL_OR_LOCK 3'h1
`define DEVSEL_AND_PASS 3'h2
`define DEVSEL_AND_PASS2 3'h3
`define DEVSEL_FSYNC 3'h4

// Output port selections
`define TXSEL_AND_PASS 3'h0
`define TXSEL_OR_PASS 3'h1
`define TXSEL_FV 3'h2
`define TXSEL_LV 3'h3
`define TXSEL_SYNCED 3'h4
`define TXSEL_IRQ 3'h5

`endif

// ### gpio_sync2.v
// Purpose: two-stage synchroniser for the pin inputs
// Assumes: pins may change at any time
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module gpio_sync2
(
    // Clocking
    input wire clock,
    input wire rst,
    input wire ce,
    // Data
    input wire [7:0] d,
    output wire [7:0] q
);

reg [7:0] meta_reg;
reg [7:0] stable_reg;

// Two flops back to back against metastability
always @(posedge clock)
begin
    if (rst)
    begin
        meta_reg <= 8'h00;
        stable_reg <= 8'h00;
    end
    else if (ce)
    begin
        meta_reg <= d;
        stable_reg <= meta_reg;
    end
end

assign q = stable_reg;

endmodule
`default_nettype wire

// ### gpio_pin_mux.v
// Purpose: pin level status and per-pin output source mux
// Assumes: AHB-Lite single word transfers, one slave
// Notes: all outputs registered except hreadyout and hresp
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_consts.vh"
module gpio_pin_mux
(
    // Clocking
    input wire clock,
    input wire rst,
    input wire ce,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Pins
    input wire [7:0] pin_in,
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe,
    // Receive port status, four ports
    input wire [15:0] rx_remote_pins,
    input wire [3:0] rx_lock,
    input wire [3:0] rx_pass,
    input wire [3:0] rx_frame_valid,
    input wire [3:0] rx_line_valid,
    input wire [3:0] rx_port_enable,
    // Device wide
    input wire frame_sync_pulse,
    // Output port 0 status
    input wire [3:0] tx_port_select,
    input wire tx_frame_valid,
    input wire tx_line_valid,
    input wire tx_synchronized,
    input wire tx_interrupt
);

// Register file
reg [7:0] input_en_reg;
reg [7:0] pin_ctl_reg [0:7];
reg [7:0] status_reg;

// Bus data phase state
reg wr_pend_reg;
reg [5:0] wr_idx_reg;

// Synchronised pin levels
wire [7:0] pin_sync;

// Next pin outputs
reg [7:0] out_next;
reg [7:0] oe_next;

// Address phase decode
wire addr_take;
wire [5:0] addr_idx;

// Every live level that the mux reads, in one bundle
wire [44:0] live_levels;

// Loop counters; one per process so no variable has two drivers
integer i;
integer j;

// Word index of a byte address; upper bits alias
function [5:0] word_index;
    input [31:0] addr;
    begin
        word_index = addr[7:2];
    end
endfunction

// Whether an index is one of the pin control registers
function is_pin_ctl;
    input [5:0] idx;
    begin
        is_pin_ctl = (idx >= `IDX_PIN0_CTL) &&
                     (idx <= `IDX_PIN7_CTL);
    end
endfunction

// Output level chosen by one control register. Live levels come in as
// an argument: a combinational caller wakes only on its arguments, so
// a level read straight from a port would leave the mux stale.
function pin_level;
    input [7:0] ctl;
    input [44:0] live;
    reg [2:0] src;
    reg [2:0] sel;
    reg [3:0] rem_idx;
    reg [3:0] sel_pass;
    reg [15:0] remote;
    reg [3:0] lock;
    reg [3:0] pass;
    reg [3:0] fv;
    reg [3:0] lv;
    reg [3:0] port_en;
    reg fsync;
    reg [3:0] tx_sel;
    reg [3:0] tx_bits;
    begin
        {remote, lock, pass, fv, lv, port_en, fsync, tx_sel, tx_bits} = live;
        src = ctl[`CTL_SRC_HI:`CTL_SRC_LO];
        sel = ctl[`CTL_SEL_HI:`CTL_SEL_LO];
        rem_idx = {src[1:0], sel[1:0]};
        sel_pass = pass | ~tx_sel;
        pin_level = 1'b0;
        // Source codes 0xx are the receive ports
        if (src[2] == 1'b0)
        begin
            case (sel)
                `RXSEL_LOCK:
                    pin_level = lock[src[1:0]];
                `RXSEL_PASS:
                    pin_level = pass[src[1:0]];
                `RXSEL_FV:
                    pin_level = fv[src[1:0]];
                `RXSEL_LV:
                    pin_level = lv[src[1:0]];
                default:
                    pin_level = remote[rem_idx];
            endcase
        end
        else if (src == `SRC_DEV_STATUS)
        begin
            case (sel)
                `DEVSEL_SW_LEVEL:
                    pin_level = ctl[`CTL_SW_LEVEL_BIT];
                `DEVSEL_OR_LOCK:
                    pin_level = |(lock & port_en);
                `DEVSEL_AND_PASS,
                `DEVSEL_AND_PASS2:
                    pin_level = &(pass | ~port_en);
                `DEVSEL_FSYNC:
                    pin_level = fsync;
                default:
                    pin_level = 1'b0; // Reserved codes
            endcase
        end
        else if (src == `SRC_OUT_PORT0)
        begin
            case (sel)
                `TXSEL_AND_PASS:
                    pin_level = &sel_pass;
                `TXSEL_OR_PASS:
                    pin_level = |(pass & tx_sel);
                `TXSEL_FV:
                    pin_level = tx_bits[3];
                `TXSEL_LV:
                    pin_level = tx_bits[2];
                `TXSEL_SYNCED:
                    pin_level = tx_bits[1];
                `TXSEL_IRQ:
                    pin_level = tx_bits[0];
                default:
                    pin_level = 1'b0; // Reserved codes
            endcase
        end
    end
endfunction

// Read value of a register index; unmapped reads zero
function [7:0] reg_read;
    input [5:0] idx;
    begin
        if (idx == `IDX_PIN_STATUS)
            reg_read = status_reg;
        else if (idx == `IDX_INPUT_EN)
            reg_read = input_en_reg;
        else if (is_pin_ctl(idx))
            reg_read = pin_ctl_reg[idx[2:0]];
        else
            reg_read = 8'h00;
    end
endfunction

// Pins pass a synchroniser before anything looks at them
gpio_sync2 pin_sync_inst
(
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .d(pin_in),
    .q(pin_sync)
);

// Zero wait states; clock enable low stalls the bus
assign hreadyout = ce;
assign hresp = 1'b0;

// Live levels bundled for the mux; order matches pin_level's unpacking
assign live_levels = {rx_remote_pins, rx_lock, rx_pass, rx_frame_valid,
    rx_line_valid, rx_port_enable, frame_sync_pulse, tx_port_select,
    tx_frame_valid, tx_line_valid, tx_synchronized, tx_interrupt};

// A transfer is taken on NONSEQ or SEQ with hready high
assign addr_take = hsel && htrans[1] && hready && ce;
assign addr_idx = word_index(haddr);

// Address phase capture and read data
always @(posedge clock)
begin
    if (rst)
    begin
        wr_pend_reg <= 1'b0;
        wr_idx_reg <= 6'h00;
        hrdata <= 32'h00000000;
    end
    else if (ce)
    begin
        wr_pend_reg <= addr_take && hwrite;
        if (addr_take)
            wr_idx_reg <= addr_idx;
        // Read data sampled here, stands in the data phase
        if (addr_take && !hwrite)
            hrdata <= {24'h000000, reg_read(addr_idx)};
    end
end

// Register writes in the data phase
always @(posedge clock)
begin
    if (rst)
    begin
        input_en_reg <= `RST_INPUT_EN;
        for (i = 0; i < 8; i = i + 1)
            pin_ctl_reg[i] <= `RST_PIN_CTL;
    end
    else if (ce && wr_pend_reg)
    begin
        if (wr_idx_reg == `IDX_INPUT_EN)
            input_en_reg <= hwdata[7:0];
        // Same layout at every pin, pin n at 0x10 + n
        if (is_pin_ctl(wr_idx_reg))
            pin_ctl_reg[wr_idx_reg[2:0]] <= hwdata[7:0];
        // Writes to the status index fall through unused
    end
end

// Status snapshot; disabled inputs read as zero
always @(posedge clock)
begin
    if (rst)
        status_reg <= `RST_PIN_STATUS;
    else if (ce)
        status_reg <= pin_sync & input_en_reg;
end

// Per-pin source mux and driver enable
always @*
begin
    out_next = 8'h00;
    oe_next = 8'h00;
    for (j = 0; j < 8; j = j + 1)
    begin
        oe_next[j] = pin_ctl_reg[j][`CTL_DRV_EN_BIT];
        // Level held low while the driver is off
        if (pin_ctl_reg[j][`CTL_DRV_EN_BIT])
            out_next[j] = pin_level(pin_ctl_reg[j], live_levels);
    end
end

// Registered pin outputs avoid glitches from the mux
always @(posedge clock)
begin
    if (rst)
    begin
        pin_out <= 8'h00;
        pin_oe <= 8'h00;
    end
    else if (ce)
    begin
        pin_out <= out_next;
        pin_oe <= oe_next;
    end
end

endmodule
`default_nettype wire

// ### gpio_pin_mux_props.sv
// Purpose: port checks for the pin mux
// Assumes: hready is tied to hreadyout, ce high during reset
// Notes: register contents are not visible from here
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_mux_props
(
    // Clocking
    input wire clock,
    input wire rst,
    input wire ce,
    // Bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // Pins
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    // Address phase taken by the slave
    wire take = hsel && htrans[1] && hready && ce;
    wire [5:0] idx = haddr[7:2];
    // Write address phase taken; the register changes one edge later and
    // the enables one edge after that, so a change looks two edges back
    logic wph_reg;
    always @(posedge clock)
        wph_reg <= !rst && take && hwrite;
    a_ready_ce: assert property (hreadyout == ce)
        else $error("ready does not follow ce");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_data_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_out_gated: assert property ((pin_out & ~pin_oe) == 8'h0)
        else $error("level on undriven pin");
    a_read_holds: assert property (!(take && !hwrite)
        |=> $stable(hrdata))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (take && !hwrite
        && (idx < 6'h0E || idx > 6'h17) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_frozen_ce: assert property (!ce
        |=> $stable(pin_out) && $stable(pin_oe))
        else $error("pins moved with ce low");
    a_reset_clear: assert property ($fell(rst) |-> pin_oe == 8'h0
        && pin_out == 8'h0 && hrdata == 32'h0)
        else $error("outputs not cleared by reset");
    a_oe_after_write: assert property (pin_oe != $past(pin_oe)
        |-> $past(wph_reg, 2))
        else $error("driver enable moved without write");
endmodule
bind gpio_pin_mux gpio_pin_mux_props props (.clock, .rst, .ce, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
    .pin_out, .pin_oe);
`default_nettype wire

// ### pin_board.sv
// Purpose: circuitry outside the pins
// Assumes: undriven pins follow the outside level
// Notes: a driven pin shows the block's own level
`timescale 1ns/100ps
`default_nettype none
module pin_board
(
    // Block side
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    // Outside level and wire
    input wire [7:0] ext_level,
    output logic [7:0] pin_in
);
    // Driven pins win over the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// ### test_gpio_pin_mux.sv
// Purpose: self-checking bench of the pin mux
// Assumes: slave answers whenever ce is high
// Notes: every control code of pins 0 to 7 is driven
`timescale 1ns/100ps
`default_nettype none
module test_gpio_pin_mux;
    logic clock = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_data, r;
    logic [31:0] seed = 32'h2960;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] rx_remote_pins = 0;
    logic [3:0] rx_lock = 0, rx_pass = 0, rx_fv = 0, rx_lv = 0;
    logic [3:0] rx_en = 0, tx_sel = 0;
    logic fsync = 0, tx_fv = 0, tx_lv = 0, tx_sync = 0, tx_irq = 0;
    logic [7:0] ext_level = 0, pin_in, pin_out, pin_oe, ien;
    logic [7:0] ctl [8];
    int bad_count = 0, checks_done = 0;
    // Free running clock
    always #5 clock = ~clock;
    gpio_pin_mux dut (.clock(clock), .rst(rst), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .rx_remote_pins(rx_remote_pins), .rx_lock(rx_lock),
        .rx_pass(rx_pass), .rx_frame_valid(rx_fv), .rx_line_valid(rx_lv),
        .rx_port_enable(rx_en), .frame_sync_pulse(fsync),
        .tx_port_select(tx_sel), .tx_frame_valid(tx_fv),
        .tx_line_valid(tx_lv), .tx_synchronized(tx_sync),
        .tx_interrupt(tx_irq));
    pin_board board (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext_level), .pin_in(pin_in));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected level of one pin from its control byte
    function automatic logic mux_bit(input logic [7:0] c);
        logic [2:0] s;
        logic [2:0] k;
        s = c[4:2];
        k = c[7:5];
        if (s < 3'h4)
            return k < 3'h4 ? rx_remote_pins[{s[1:0], k[1:0]}] :
                k == 3'h4 ? rx_lock[s[1:0]] : k == 3'h5 ? rx_pass[s[1:0]] :
                k == 3'h6 ? rx_fv[s[1:0]] : rx_lv[s[1:0]];
        if (s == 3'h4)
            return k == 3'h0 ? c[1] : k == 3'h1 ? |(rx_lock & rx_en) :
                k < 3'h4 ? &(rx_pass | ~rx_en) : k == 3'h4 & fsync;
        if (s == 3'h6)
            return k == 3'h0 ? &(rx_pass | ~tx_sel) :
                k == 3'h1 ? |(rx_pass & tx_sel) : k == 3'h2 ? tx_fv :
                k == 3'h3 ? tx_lv : k == 3'h4 ? tx_sync : k == 3'h5 & tx_irq;
        return 1'b0;
    endfunction
    // Expected enables over levels of all pins
    function automatic logic [15:0] model_pins();
        logic [15:0] v;
        for (int p = 0; p < 8; p++)
        begin
            v[p + 8] = ctl[p][0];
            v[p] = ctl[p][0] & mux_bit(ctl[p]);
        end
        return v;
    endfunction
    task automatic wrap_up();
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            $display("mismatch at %0t: bus never ready", $time);
            bad_count++;
            wrap_up();
        end
    endtask
    // One single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd_data = hrdata;
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        bus(0, 32'h3C, 0);
        check(rd_data, 32'hFF);
        for (int p = 0; p < 8; p++)
        begin
            ctl[p] = 8'h00;
            bus(0, {24'h0, 3'h2, p[2:0], 2'h0}, 0);
            check(rd_data, 32'h0);
        end
        r = rnd();
        ext_level <= r[7:0];
        ien = r[15:8];
        bus(1, 32'h3C, {24'h0, ien});
        bus(1, 32'h38, ~r);
        bus(1, 32'h00, r);
        repeat (5) @(posedge clock);
        bus(0, 32'h38, 0);
        check(rd_data, {24'h0, r[7:0] & ien});
        bus(0, 32'h3C, 0);
        check(rd_data, {24'h0, ien});
        bus(0, 32'h00, 0);
        check(rd_data, 32'h0);
        for (int i = 0; i < 2048; i++)
        begin
            r = rnd();
            rx_remote_pins <= r[15:0];
            {rx_lock, rx_pass, rx_fv, rx_lv} <= r[31:16];
            r = rnd();
            {rx_en, tx_sel} <= {r[3:0] | 4'h1, r[7:4]};
            {fsync, tx_fv, tx_lv, tx_sync, tx_irq} <= r[12:8];
            ext_level <= r[23:16];
            ce <= i[3:0] != 4'h5;
            ctl[i[10:8]] = i[7:0];
            @(posedge clock);
            ce <= 1'b1;
            bus(1, {24'h0, 3'h2, i[10:8], 2'h0}, {24'h0, i[7:0]});
            repeat (2) @(posedge clock);
            r[15:0] = model_pins();
            check(pin_oe, r[15:8]);
            check(pin_out[3:0], r[3:0]);
            check(pin_out[7:4], r[7:4]);
            if (i[5:0] == 6'h0)
            begin
                r[15:0] = model_pins();
                repeat (4) @(posedge clock);
                bus(0, 32'h38, 0);
                r[31:24] = (r[15:8] & r[7:0]) | (~r[15:8] & ext_level);
                check(rd_data, {24'h0, r[31:24] & ien});
                bus(0, {24'h0, 3'h2, i[10:8], 2'h0}, 0);
                check(rd_data, {24'h0, i[7:0]});
            end
        end
        wrap_up();
    end
endmodule
`default_nettype wire
